// ===== nac_map.svh
`ifndef NAC_MAP_SVH
`define NAC_MAP_SVH

// Register byte offsets
`define NAC_CTRL 8'h00
`define NAC_STATUS 8'h04
`define NAC_RATE 8'h08
`define NAC_RTK 8'h0c
`define NAC_ANGLE 8'h10
`define NAC_SPEED 8'h14
`define NAC_HDG 8'h18
`define NAC_CAR0 8'h20
`define NAC_CAR4 8'h30
`define NAC_MAG0 8'h40
`define NAC_MAG3 8'h4c
`define NAC_MAGF 8'h50
`define NAC_DVS0 8'h80
`define NAC_DVS14 8'hb8

// Control bits
`define NAC_C_CLR_EXT 4
`define NAC_C_CLR_DROP 5

// Packet identifiers and payload lengths
`define NAC_ID_DVS 8'h46
`define NAC_ID_GIM 8'h48
`define NAC_ID_CAR 8'h49
`define NAC_ID_MAG 8'h4b
`define NAC_LEN_DVS 8'h3c
`define NAC_LEN_GIM 8'h08
`define NAC_LEN_CAR 8'h18
`define NAC_LEN_MAG 8'h11

// Flag masks
`define NAC_DVS_FLAGS 32'h0000001f
`define NAC_MAG_FLAGS 8'h03
`define NAC_DVS_FLAG_WORD 2

// Single-precision constants
`define NAC_TWO_PI 32'h40c90fdb
`define NAC_PI 32'h40490fdb
`define NAC_SLIP_MIN 32'h405ccccd

// Accuracy codes
`define NAC_RTK_UNKNOWN 3'h0
`define NAC_RTK_MAX 3'h5

`endif

// ===== nac_pkg.sv
package nac_pkg;

    typedef enum logic {TX_IDLE, TX_SEND} nac_tx_e;

    typedef struct packed {
        logic [31:0] prdata;
        logic perr;
        nac_tx_e txs;
        logic [1:0] tx_sel;
        logic [5:0] tx_idx;
        logic [3:0] pend;
        logic [1:0] rx_sel;
        logic rx_ok;
        logic [5:0] rx_cnt;
        logic [14:0][31:0] stage;
        logic [14:0][31:0] dvs;
        logic [31:0] angle;
        logic [31:0] speed;
        logic hdg_ok;
        logic [4:0][31:0] car;
        logic [3:0][31:0] mag;
        logic [7:0] mag_flags;
        logic [31:0] rate;
        logic [31:0] rate_cnt;
        logic [2:0] rtk;
        logic ext_hdg;
        logic drop;
        logic [1:0] qcnt;
        logic [1:0][16:0] q;
    } nac_state_s;

endpackage

// ===== nac_codec.sv
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "nac_map.svh"
module nac_codec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_start,
    input wire logic [7:0] in_id,
    input wire logic [7:0] in_len,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic [7:0] out_id,
    output logic out_last,
    output logic ext_heading,
    output logic [2:0] rtk_accuracy
);

    nac_pkg::nac_state_s s;
    nac_pkg::nac_state_s n;
    logic pop;
    logic push;
    logic [31:0] word;
    logic [7:0] tx_len;

    // Open range check for a written angle
    function automatic logic angle_ok(input logic [31:0] a);
        angle_ok = a[30:0] < 31'(`NAC_TWO_PI);
    endfunction

    // Fold an angle in (pi, 2pi) back by 2pi
    function automatic logic [31:0] wrap(input logic [31:0] a);
        logic [25:0] m;
        logic [25:0] d;
        logic [25:0] sh;
        logic [4:0] p;
        wrap = a;
        m = 26'h0;
        p = 5'h0;
        if (a[30:0] > 31'(`NAC_PI)) begin
            if (a[30:23] == 8'h80) begin
                m = {1'b0, 1'b1, a[22:0], 1'b0};
            end else begin
                m = {1'b1, a[22:0], 2'b0};
            end
            d = {1'b1, 23'(`NAC_TWO_PI), 2'b0};
            d = d - m;
            for (int i = 0; i < 26; i++) begin
                if (d[i]) begin
                    p = 5'(i);
                end
            end
            sh = d << (5'd25 - p);
            wrap = {~a[31], 8'd104 + {3'b0, p}, sh[24:2]};
        end
    endfunction

    // Payload length of the packet being sent
    always_comb begin
        unique case (s.tx_sel)
            2'd0: tx_len = `NAC_LEN_DVS;
            2'd1: tx_len = `NAC_LEN_GIM;
            2'd2: tx_len = `NAC_LEN_CAR;
            2'd3: tx_len = `NAC_LEN_MAG;
        endcase
    end

    // Word holding the byte about to be sent
    always_comb begin
        word = 32'h0;
        unique case (s.tx_sel)
            2'd0: word = s.dvs[s.tx_idx[5:2]];
            2'd1: begin
                if (s.tx_idx < 6'd4) begin
                    word = wrap(s.angle);
                end
            end
            2'd2: begin
                if (s.tx_idx < 6'd20) begin
                    word = s.car[s.tx_idx[4:2]];
                end
                if (s.tx_idx[4:2] == 3'd1 && (!s.hdg_ok || s.speed[31]
                    || s.speed[30:0] <= 31'(`NAC_SLIP_MIN))) begin
                    word = 32'h0;
                end
            end
            2'd3: begin
                if (s.tx_idx < 6'd16) begin
                    word = s.mag[s.tx_idx[3:2]];
                end else begin
                    word = {24'h0, s.mag_flags};
                end
            end
        endcase
    end

    // Two-entry output buffer handshake
    assign out_valid = s.qcnt != 2'd0;
    assign pop = out_valid && out_ready;
    assign push = s.txs == nac_pkg::TX_SEND && (s.qcnt != 2'd2 || pop);
    assign out_last = s.q[0][16];
    assign out_id = s.q[0][15:8];
    assign out_data = s.q[0][7:0];

    // APB outputs, then the heading and accuracy ports
    assign pready = psel && penable;
    assign pslverr = pready && s.perr;
    assign prdata = s.prdata;
    assign ext_heading = s.ext_hdg;
    assign rtk_accuracy = s.rtk;

    // Next state
    always_comb begin
        logic [7:0] a;
        logic [7:0] id;
        a = paddr[7:0];
        id = 8'h0;
        n = s;

        // Read data and error captured in the setup phase
        if (psel && !penable) begin
            n.perr = paddr[11:8] != 4'h0 || paddr[1:0] != 2'b0;
            n.prdata = 32'h0;
            if (a == `NAC_CTRL) begin
                n.prdata = {28'h0, s.pend};
            end else if (a == `NAC_STATUS) begin
                n.prdata = {27'h0, s.mag_flags[1:0], s.drop,
                    s.txs == nac_pkg::TX_SEND, s.ext_hdg};
            end else if (a == `NAC_RATE) begin
                n.prdata = s.rate;
            end else if (a == `NAC_RTK) begin
                n.prdata = {29'h0, s.rtk};
            end else if (a == `NAC_ANGLE) begin
                n.prdata = s.angle;
            end else if (a == `NAC_SPEED) begin
                n.prdata = s.speed;
            end else if (a == `NAC_HDG) begin
                n.prdata = {31'h0, s.hdg_ok};
            end else if (a >= `NAC_CAR0 && a <= `NAC_CAR4) begin
                n.prdata = s.car[3'(a[5:2] - 4'h8)];
            end else if (a >= `NAC_MAG0 && a <= `NAC_MAG3) begin
                n.prdata = s.mag[a[3:2]];
            end else if (a == `NAC_MAGF) begin
                n.prdata = {24'h0, s.mag_flags};
            end else if (a >= `NAC_DVS0 && a <= `NAC_DVS14) begin
                n.prdata = s.dvs[a[5:2]];
            end else begin
                n.perr = 1'b1;
            end
        end

        // Register writes at the access phase
        if (psel && penable && pwrite && !s.perr) begin
            if (a == `NAC_CTRL) begin
                n.pend = s.pend | pwdata[3:0];
                if (pwdata[`NAC_C_CLR_EXT]) begin
                    n.ext_hdg = 1'b0;
                end
                if (pwdata[`NAC_C_CLR_DROP]) begin
                    n.drop = 1'b0;
                end
            end else if (a == `NAC_RATE) begin
                n.rate = pwdata;
                n.rate_cnt = 32'h0;
            end else if (a == `NAC_RTK) begin
                n.rtk = pwdata[2:0] > `NAC_RTK_MAX ? `NAC_RTK_UNKNOWN
                    : pwdata[2:0];
            end else if (a == `NAC_ANGLE) begin
                if (angle_ok(pwdata)) begin
                    n.angle = pwdata;
                end
            end else if (a == `NAC_SPEED) begin
                n.speed = pwdata;
            end else if (a == `NAC_HDG) begin
                n.hdg_ok = pwdata[0];
            end else if (a >= `NAC_CAR0 && a <= `NAC_CAR4) begin
                n.car[3'(a[5:2] - 4'h8)] = pwdata;
            end
        end

        // Inbound header check
        if (in_start) begin
            n.rx_cnt = 6'h0;
            n.rx_ok = 1'b1;
            if (in_id == `NAC_ID_DVS && in_len == `NAC_LEN_DVS) begin
                n.rx_sel = 2'd0;
            end else if (in_id == `NAC_ID_GIM && in_len == `NAC_LEN_GIM) begin
                n.rx_sel = 2'd1;
            end else if (in_id == `NAC_ID_MAG && in_len == `NAC_LEN_MAG) begin
                n.rx_sel = 2'd3;
            end else begin
                n.rx_ok = 1'b0;
                n.drop = 1'b1;
            end
        end

        // Inbound bytes, low byte of each field first
        if (in_valid && s.rx_ok && s.rx_cnt < 6'd60) begin
            n.stage[s.rx_cnt[5:2]][s.rx_cnt[1:0]*8 +: 8] = in_data;
            n.rx_cnt = s.rx_cnt + 6'd1;
        end
        if (in_valid && in_last) begin
            n.rx_ok = 1'b0;
            unique case (s.rx_sel)
                2'd0: id = `NAC_LEN_DVS;
                2'd1: id = `NAC_LEN_GIM;
                2'd2: id = `NAC_LEN_CAR;
                2'd3: id = `NAC_LEN_MAG;
            endcase
            if (!s.rx_ok || {2'b0, s.rx_cnt} + 8'd1 != id) begin
                n.drop = 1'b1;
            end else if (s.rx_sel == 2'd0) begin
                n.dvs = n.stage;
                n.dvs[`NAC_DVS_FLAG_WORD] = n.stage[`NAC_DVS_FLAG_WORD]
                    & `NAC_DVS_FLAGS;
                if (s.rate == 32'h0) begin
                    n.pend[0] = 1'b1;
                end
            end else if (s.rx_sel == 2'd1) begin
                if (angle_ok(n.stage[0])) begin
                    n.angle = n.stage[0];
                end else begin
                    n.drop = 1'b1;
                end
            end else begin
                n.mag = n.stage[3:0];
                n.mag_flags = n.stage[4][7:0] & `NAC_MAG_FLAGS;
                n.ext_hdg = 1'b1;
            end
        end

        // Fixed output rate for the velocity-sensor packet
        if (s.rate != 32'h0) begin
            n.rate_cnt = s.rate_cnt + 32'h1;
            if (s.rate_cnt >= s.rate - 32'h1) begin
                n.rate_cnt = 32'h0;
                n.pend[0] = 1'b1;
            end
        end

        // Serializer: lowest pending packet first
        unique case (s.txs)
            nac_pkg::TX_IDLE: begin
                for (int i = 3; i >= 0; i--) begin
                    if (s.pend[i]) begin
                        n.tx_sel = 2'(i);
                    end
                end
                if (s.pend != 4'h0) begin
                    n.pend[n.tx_sel] = 1'b0;
                    n.tx_idx = 6'h0;
                    n.txs = nac_pkg::TX_SEND;
                end
            end
            nac_pkg::TX_SEND: begin
                if (push) begin
                    n.tx_idx = s.tx_idx + 6'd1;
                    if ({2'b0, s.tx_idx} == tx_len - 8'd1) begin
                        n.txs = nac_pkg::TX_IDLE;
                    end
                end
            end
        endcase

        // Buffer shift and fill
        if (pop) begin
            n.q[0] = s.q[1];
            n.qcnt = s.qcnt - 2'd1;
        end
        if (push) begin
            id = 8'h0;
            unique case (s.tx_sel)
                2'd0: id = `NAC_ID_DVS;
                2'd1: id = `NAC_ID_GIM;
                2'd2: id = `NAC_ID_CAR;
                2'd3: id = `NAC_ID_MAG;
            endcase
            n.q[n.qcnt[0]] = {{2'b0, s.tx_idx} == tx_len - 8'd1, id,
                word[s.tx_idx[1:0]*8 +: 8]};
            n.qcnt = n.qcnt + 2'd1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule

// ===== nac_codec_sva.sv
`timescale 1ns/100ps
module nac_codec_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_start,
    input wire logic [7:0] in_id,
    input wire logic [7:0] in_len,
    input wire logic in_valid,
    input wire logic in_last,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic [7:0] out_id,
    input wire logic out_last,
    input wire logic ext_heading,
    input wire logic [2:0] rtk_accuracy
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Whole inbound magnetometer packet
    sequence s_mag;
        in_start && in_id == 8'h4b && in_len == 8'h11 ##1
        in_valid [*8] ##1 in_valid [*8] ##1 in_valid && in_last;
    endsequence
    sequence s_tail(logic [7:0] id);
        out_valid && out_last && out_id == id;
    endsequence
    // Bus, stream and packet checks
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    a_misalign_err: assert property (psel && !penable &&
        paddr[1:0] != 2'h0 ##1 penable |-> pslverr)
        else $error("misaligned access not refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error outside access phase");
    a_stall_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_data) && $stable(out_id) && $stable(out_last))
        else $error("stalled byte changed");
    a_id_known: assert property (out_valid |-> out_id inside
        {8'h46, 8'h48, 8'h49, 8'h4b})
        else $error("unknown packet id sent");
    a_rtk_range: assert property (rtk_accuracy <= 3'h5)
        else $error("accuracy code above five");
    a_mag_ext: assert property (s_mag |=> ext_heading)
        else $error("external heading not set");
    a_ext_cause: assert property ($rose(ext_heading) |-> $past(in_last))
        else $error("external heading set without packet");
    a_gim_tail: assert property (s_tail(8'h48) |-> out_data == 8'h00)
        else $error("gimbal reserved byte not zero");
    a_car_tail: assert property (s_tail(8'h49) |-> out_data == 8'h00)
        else $error("automotive reserved byte not zero");
    a_mag_flags: assert property (s_tail(8'h4b) |-> out_data[7:2] == 6'h0)
        else $error("unused magnetometer flag set");
endmodule
bind nac_codec nac_codec_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .in_start(in_start), .in_id(in_id), .in_len(in_len),
    .in_valid(in_valid), .in_last(in_last), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_id(out_id),
    .out_last(out_last), .ext_heading(ext_heading),
    .rtk_accuracy(rtk_accuracy));

// ===== nac_host_sink.sv
`timescale 1ns/100ps
module nac_host_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic [7:0] out_id,
    input wire logic out_last,
    output logic out_ready,
    output logic got,
    output logic [16:0] got_word
);
    logic [2:0] ph;
    // Host stalls three cycles in every eight
    assign out_ready = ph < 3'h5;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 3'h0;
            got <= 1'b0;
            got_word <= 17'h0;
        end else begin
            ph <= ph + 3'h1;
            got <= out_valid && out_ready;
            got_word <= {out_id, out_last, out_data};
        end
    end
endmodule

// ===== nac_tb.sv
`timescale 1ns/100ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, got;
    logic in_start, in_valid, in_last, out_valid, out_ready, out_last;
    logic ext_heading;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, a;
    logic [7:0] in_id, in_len, in_data, out_data, out_id;
    logic [2:0] rtk_accuracy;
    logic [16:0] got_word, b;
    logic [1:0] mf;
    logic [7:0] pl [0:63];
    logic [16:0] rx_q [$];
    int mismatches, cmp_count;
    nac_codec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_start(in_start), .in_id(in_id), .in_len(in_len),
        .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_id(out_id), .out_last(out_last), .ext_heading(ext_heading),
        .rtk_accuracy(rtk_accuracy));
    nac_host_sink u_host (.pclk(pclk), .presetn(presetn),
        .out_valid(out_valid), .out_data(out_data), .out_id(out_id),
        .out_last(out_last), .out_ready(out_ready), .got(got),
        .got_word(got_word));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (got) rx_q.push_back(got_word);
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [31:0] wd(input int i);
        return {pl[i + 3], pl[i + 2], pl[i + 1], pl[i]};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // APB master, one transfer
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge pclk);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task rchk(input string n, input logic [11:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(n, e, rd);
    endtask
    // Inbound packet from pl, header then one byte a cycle
    task send(input logic [7:0] id, input logic [7:0] len, input int n);
        @(posedge pclk);
        {in_start, in_id, in_len} <= {1'b1, id, len};
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            {in_start, in_valid, in_data, in_last} <= {2'h1, pl[i], i == n - 1};
        end
        @(posedge pclk);
        {in_valid, in_last} <= 2'h0;
        repeat (3) @(posedge pclk);
    endtask
    task fill(input int n);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            pl[i] = seed[7:0];
        end
    endtask
    // Collect n outbound bytes and compare with pl
    task take(input logic [7:0] id, input int n);
        for (int w = 0; w < 400 && rx_q.size() < n; w++) @(posedge pclk);
        for (int i = 0; i < n; i++)
            chk("out byte", {id, i == n - 1, pl[i]},
                rx_q.size() > 0 ? rx_q.pop_front() : 17'h0);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_of_test;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {in_start, in_valid, in_last, in_id, in_len, in_data} = '0;
        {presetn, mismatches, cmp_count, seed} = {65'h0, 32'hbeec44ea};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, 12'h00c, 32'(v));
            rchk("rtk", 12'h00c, v > 5 ? 32'h0 : 32'(v));
            chk("rtk port", v > 5 ? 32'h0 : 32'(v), 32'(rtk_accuracy));
        end
        apb(1'b0, 12'h002, 32'h0);
        chk("misaligned", 32'h1, 32'(er));
        apb(1'b0, 12'h05c, 32'h0);
        chk("unmapped", 32'h1, 32'(er));
        fill(17);
        send(8'h4b, 8'h11, 17);
        pl[16] = pl[16] & 8'h03;
        mf = pl[16][1:0];
        for (int i = 0; i < 4; i++)
            rchk("mag", 12'h040 + 12'(4 * i), wd(4 * i));
        rchk("status", 12'h004, {27'h0, pl[16][1:0], 3'h1});
        apb(1'b1, 12'h000, 32'h8);
        take(8'h4b, 17);
        fill(60);
        send(8'h46, 8'h3c, 60);
        {pl[11], pl[10], pl[9], pl[8]} = {24'h0, pl[8] & 8'h1f};
        take(8'h46, 60);
        {pl[3], pl[2], pl[1], pl[0], pl[4], pl[5], pl[6], pl[7]} =
            {32'h3f800000, 32'h0};
        send(8'h48, 8'h08, 8);
        apb(1'b1, 12'h000, 32'h2);
        take(8'h48, 8);
        {pl[3], pl[2], pl[1], pl[0]} = 32'h40800000;
        send(8'h48, 8'h08, 8);
        apb(1'b1, 12'h000, 32'h2);
        for (int w = 0; w < 400 && rx_q.size() < 8; w++) @(posedge pclk);
        // Angle word is the first four bytes, low byte first
        for (int i = 0; i < 8; i++) begin
            b = rx_q.size() > 0 ? rx_q.pop_front() : 17'h0;
            if (i < 4) a = {b[7:0], a[31:8]};
        end
        chk("wrap", 32'h1, 32'(a >= 32'hc0121fb0 && a <= 32'hc0121fba));
        // Wrong length, read-only id, angle out of range
        for (int t = 0; t < 3; t++) begin
            apb(1'b1, 12'h000, 32'h20);
            {pl[3], pl[2], pl[1], pl[0]} = 32'h40d00000;
            send(t == 0 ? 8'h46 : t == 1 ? 8'h49 : 8'h48,
                t == 0 ? 8'h3b : t == 1 ? 8'h18 : 8'h08, t == 0 ? 59 : 8);
            rchk("drop", 12'h004, {27'h0, mf, 3'h5});
        end
        chk("no output", 32'h0, 32'(rx_q.size()));
        // Slip gating: speed at limit, no heading, both met
        fill(24);
        {pl[23], pl[22], pl[21], pl[20]} = 32'h0;
        for (int i = 0; i < 5; i++)
            apb(1'b1, 12'h020 + 12'(4 * i), wd(4 * i));
        a = wd(4);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, 12'h014, c == 0 ? 32'h405ccccd : 32'h40600000);
            apb(1'b1, 12'h018, c == 1 ? 32'h0 : 32'h1);
            {pl[7], pl[6], pl[5], pl[4]} = c == 2 ? a : 32'h0;
            apb(1'b1, 12'h000, 32'h4);
            take(8'h49, 24);
        end
        // Fixed rate: packet sent per period with no arrival
        apb(1'b1, 12'h008, 32'd150);
        repeat (100) @(posedge pclk);
        chk("rate early", 32'h0, 32'(rx_q.size()));
        repeat (200) @(posedge pclk);
        chk("rate count", 32'h1, 32'(rx_q.size() >= 60));
        chk("rate id", 32'h46, 32'(rx_q[0][16:9]));
        end_of_test;
    end
endmodule
